// ==== rocs_pkg.sv ====
package rocs_pkg;
    // frequencies are in 0.01 Hz steps; 400.00 Hz needs 16 bits
    localparam int FREQ_W = 16;
    localparam logic [15:0] FREQ_SET_MAX = 16'h9c40;
    localparam logic [15:0] DET_LEVEL_DFLT = 16'h0bb8;
    localparam logic [15:0] DET_BW_DFLT = 16'h03e8;
    localparam int SEL_W = 5;
    localparam logic [4:0] SEL_MODE1 = 5'h00;
    localparam logic [4:0] SEL_MODE2 = 5'h01;
    localparam logic [4:0] SEL_MODE3 = 5'h02;
    localparam logic [4:0] SEL_MODE4 = 5'h03;
    localparam logic [4:0] SEL_MODE5 = 5'h04;
    localparam logic [4:0] SEL_OV = 5'h08;
    localparam logic [4:0] SEL_UV = 5'h09;
    localparam logic [4:0] SEL_OH = 5'h0a;
    localparam logic [4:0] SEL_LOSS = 5'h0b;
    localparam logic [4:0] SEL_RUN = 5'h0c;
    localparam logic [4:0] SEL_STOP = 5'h0d;
    localparam logic [4:0] SEL_CONST = 5'h0e;
    localparam logic [4:0] SEL_WAIT = 5'h10;
    localparam logic [4:0] SEL_FAULT = 5'h11;
    localparam logic [4:0] SEL_FAN = 5'h12;
    localparam logic [4:0] RELAY_ONE_SEL_DFLT = 5'h0c;
    localparam logic [4:0] RELAY_TWO_SEL_DFLT = 5'h11;
    localparam int DET_ONE = 0;
    localparam int DET_TWO = 1;
    localparam int DET_THREE = 2;
    localparam int DET_FOUR = 3;
    localparam int DET_FIVE = 4;
    localparam int FMASK_UV = 0;
    localparam int FMASK_TRIP = 1;
    localparam int FMASK_RESTART = 2;
    localparam logic [2:0] FMASK_DFLT = 3'h2;
    localparam int KMASK_ONE = 0;
    localparam int KMASK_TWO = 1;
    localparam logic [1:0] KMASK_DFLT = 2'h0;
    localparam logic FAN_KEEP_RUN = 1'b0;
    localparam int CLK_HZ = 40_000_000;
    localparam int KEYPAD_ERR_PERSIST_MS = 100;
    localparam int KEYPAD_ERR_PERSIST_CYC =
        (CLK_HZ / 1000) * KEYPAD_ERR_PERSIST_MS;
endpackage : rocs_pkg

// ==== rocs_fdt_if.sv ====
`timescale 1ns/1ps
interface rocs_fdt_if;
    import rocs_pkg::*;
    logic [FREQ_W-1:0] cmd_freq;
    logic [FREQ_W-1:0] run_freq;
    logic [FREQ_W-1:0] level;
    logic [FREQ_W-1:0] bw;
    logic accel;
    logic decel;
    logic [4:0] mode;
    modport det (
        input cmd_freq, run_freq, level, bw, accel, decel,
        output mode
    );
    modport user (
        output cmd_freq, run_freq, level, bw, accel, decel,
        input mode
    );
endinterface : rocs_fdt_if

// ==== rocs_freq_detect.sv ====
`timescale 1ns/1ps
module rocs_freq_detect (
    input wire logic i_clk,
    input wire logic i_rst_b,
    rocs_fdt_if.det bus
);
    import rocs_pkg::*;
    typedef struct packed {
        logic [4:0] mode;
    } rocs_det_s;
    rocs_det_s st;
    rocs_det_s next_st;
    logic [FREQ_W-1:0] half;
    logic signed [FREQ_W+1:0] low_edge;
    logic fwd;

    function automatic logic [FREQ_W-1:0] abs_diff(
        input logic [FREQ_W-1:0] a,
        input logic [FREQ_W-1:0] b
    );
        return (a >= b) ? a - b : b - a;
    endfunction : abs_diff

    always_comb
    begin
        half = bus.bw >> 1;
        // signed: level minus half band may go below zero
        low_edge = $signed({2'b00, bus.level}) - $signed({2'b00, half});
        if (bus.decel)
        begin
            fwd = $signed({2'b00, bus.run_freq}) > low_edge; // see RULE_05
        end
        else
        begin
            fwd = bus.run_freq >= bus.level; // see RULE_05
        end
        next_st.mode[DET_ONE] =
            abs_diff(bus.cmd_freq, bus.run_freq) <= half; // see RULE_02
        next_st.mode[DET_TWO] = (bus.cmd_freq == bus.level)
            && next_st.mode[DET_ONE]; // see RULE_03
        next_st.mode[DET_THREE] =
            abs_diff(bus.level, bus.run_freq) <= half; // see RULE_04
        next_st.mode[DET_FOUR] = fwd;
        next_st.mode[DET_FIVE] = !fwd; // see RULE_06
        if (!i_rst_b)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        st <= next_st;
    end

    assign bus.mode = st.mode;

    property p_band_one;
        @(posedge i_clk) disable iff (!i_rst_b)
        (abs_diff(bus.cmd_freq, bus.run_freq) <= (bus.bw >> 1))
            |=> bus.mode[DET_ONE];
    endproperty
    a_band_one: assert property (p_band_one) // see RULE_02
        else $error("mode one missed inside band");
endmodule : rocs_freq_detect

// ==== rocs_err_persist.sv ====
`timescale 1ns/1ps
module rocs_err_persist #(
    parameter int unsigned CYC = rocs_pkg::KEYPAD_ERR_PERSIST_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_err,
    output logic o_err
);
    import rocs_pkg::*;
    localparam int CW = $clog2(CYC + 1);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic err;
    } rocs_pers_s;
    rocs_pers_s st;
    rocs_pers_s next_st;

    if (CYC < 1)
    begin : g_chk
        $error("persist count must be at least one");
    end

    always_comb
    begin
        next_st = st;
        // any good exchange restarts the wait
        if (!i_err)
        begin
            next_st = '0;
        end
        else if (st.cnt == CW'(CYC - 1))
        begin
            next_st.err = 1'b1; // see RULE_20
        end
        else
        begin
            next_st.cnt = st.cnt + 1'b1;
        end
        if (!i_rst_b)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        st <= next_st;
    end

    assign o_err = st.err;

    property p_no_early;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_err) |-> $past(i_err) && (st.cnt == CW'(CYC - 1));
    endproperty
    a_no_early: assert property (p_no_early) // see RULE_20
        else $error("keypad error reported too early");

    property p_drop;
        @(posedge i_clk) disable iff (!i_rst_b)
        !i_err |=> !o_err;
    endproperty
    a_drop: assert property (p_drop) // see RULE_20
        else $error("keypad error held without cause");
endmodule : rocs_err_persist

// ==== rocs_relay_sel.sv ====
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - select codes 0 to 4 pick detection modes one to five per relay
// RULE_02 - mode one: command and output frequency within half the band
// RULE_03 - mode two: command equals level and mode one holds
// RULE_04 - mode three: level and running frequency within half the band
// RULE_05 - mode four: accel run >= level; decel run > level minus half band
// RULE_06 - mode five is mode four inverted, a normally closed contact
// RULE_07 - level and band set 0 to 400 Hz, not above max, defaults 30/10
// RULE_08 - code 8 energises the relay on overvoltage trip
// RULE_09 - code 9 energises the relay on undervoltage trip
// RULE_10 - code 10 energises the relay on heatsink overheat
// RULE_11 - code 11 energises on analog reference or serial command loss
// RULE_12 - code 12 energises while run command present and output active
// RULE_13 - code 13 energises while stopped with no run command
// RULE_14 - code 14 energises while running at constant speed
// RULE_15 - code 16 energises in normal state waiting for a run command
// RULE_16 - code 17 follows the fault mask; mask 2 skips undervoltage
// RULE_17 - fault mask bit0 undervoltage, bit1 other trips, bit2 restart
// RULE_18 - code 18 flags fan fault only when fan behaviour is keep running
// RULE_19 - keypad error mask: bit0 to relay one, bit1 to relay two
// RULE_20 - keypad link error is reported only after it persists
// RULE_21 - relays are registered, updated each cycle, cleared by reset
// RULE_22 - keypad error and selected condition are ored per relay
module rocs_relay_sel #(
    parameter int unsigned PERSIST_CYC = rocs_pkg::KEYPAD_ERR_PERSIST_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [rocs_pkg::FREQ_W-1:0] i_cmd_freq,
    input wire logic [rocs_pkg::FREQ_W-1:0] i_run_freq,
    input wire logic [rocs_pkg::FREQ_W-1:0] i_detect_freq_level,
    input wire logic [rocs_pkg::FREQ_W-1:0] i_detect_freq_bandwidth,
    input wire logic i_accel,
    input wire logic i_decel,
    input wire logic [rocs_pkg::SEL_W-1:0] i_relay_one_select,
    input wire logic [rocs_pkg::SEL_W-1:0] i_relay_two_select,
    input wire logic [2:0] i_fault_relay_mask,
    input wire logic [1:0] i_keypad_error_output_mask,
    input wire logic i_fan_trip_behaviour,
    input wire logic i_ov_trip,
    input wire logic i_uv_trip,
    input wire logic i_other_trip,
    input wire logic i_heatsink_overheat_event,
    input wire logic i_analog_ref_lost,
    input wire logic i_comm_cmd_lost,
    input wire logic i_run_cmd,
    input wire logic i_output_active,
    input wire logic i_drive_stopped,
    input wire logic i_drive_ready,
    input wire logic i_restart_pending,
    input wire logic i_fan_fault,
    input wire logic i_keypad_link_error,
    output logic o_relay_one,
    output logic o_relay_two,
    output logic o_keypad_error,
    output logic [4:0] o_freq_detect
);
    import rocs_pkg::*;

    typedef struct packed {
        logic relay_one;
        logic relay_two;
        logic kp_err;
        logic [4:0] fdt;
    } rocs_main_s;

    rocs_main_s st;
    rocs_main_s next_st;
    logic [31:0] cond;
    logic kp_err;
    logic kp1;
    logic kp2;
    logic nonuv;
    logic any_trip;

    if (PERSIST_CYC < 1)
    begin : g_chk
        $error("persist count must be at least one");
    end

    rocs_fdt_if fdt ();

    assign fdt.cmd_freq = i_cmd_freq;
    assign fdt.run_freq = i_run_freq;
    assign fdt.level = i_detect_freq_level;
    assign fdt.bw = i_detect_freq_bandwidth;
    assign fdt.accel = i_accel;
    assign fdt.decel = i_decel;

    rocs_freq_detect u_det (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .bus(fdt.det)
    );

    rocs_err_persist #(
        .CYC(PERSIST_CYC)
    ) u_pers (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_err(i_keypad_link_error),
        .o_err(kp_err)
    );

    // same decode serves both relays
    function automatic logic relay_cond(
        input logic [SEL_W-1:0] sel,
        input logic [31:0] v
    );
        return v[sel];
    endfunction : relay_cond

    assign kp1 = kp_err && i_keypad_error_output_mask[KMASK_ONE];
    assign kp2 = kp_err && i_keypad_error_output_mask[KMASK_TWO];
    assign nonuv = i_ov_trip || i_other_trip;
    assign any_trip = nonuv || i_uv_trip;

    always_comb
    begin
        // codes handled elsewhere in the drive read as off
        cond = '0;
        cond[SEL_MODE1] = fdt.mode[DET_ONE]; // see RULE_01
        cond[SEL_MODE2] = fdt.mode[DET_TWO]; // see RULE_01
        cond[SEL_MODE3] = fdt.mode[DET_THREE]; // see RULE_01
        cond[SEL_MODE4] = fdt.mode[DET_FOUR]; // see RULE_01
        cond[SEL_MODE5] = fdt.mode[DET_FIVE]; // see RULE_06
        cond[SEL_OV] = i_ov_trip; // see RULE_08
        cond[SEL_UV] = i_uv_trip; // see RULE_09
        cond[SEL_OH] = i_heatsink_overheat_event; // see RULE_10
        cond[SEL_LOSS] = i_analog_ref_lost || i_comm_cmd_lost; // see RULE_11
        cond[SEL_RUN] = i_run_cmd && i_output_active; // see RULE_12
        cond[SEL_STOP] = i_drive_stopped && !i_run_cmd; // see RULE_13
        cond[SEL_CONST] = i_output_active
            && !i_accel && !i_decel; // see RULE_14
        cond[SEL_WAIT] = i_drive_ready && !i_run_cmd
            && !any_trip; // see RULE_15
        cond[SEL_FAULT] = (i_fault_relay_mask[FMASK_UV] && i_uv_trip)
            || (i_fault_relay_mask[FMASK_TRIP] && nonuv)
            || (i_fault_relay_mask[FMASK_RESTART]
            && i_restart_pending); // see RULE_16 RULE_17
        cond[SEL_FAN] = i_fan_fault
            && (i_fan_trip_behaviour == FAN_KEEP_RUN); // see RULE_18
    end

    always_comb
    begin
        next_st.relay_one =
            relay_cond(i_relay_one_select, cond) || kp1; // see RULE_22
        next_st.relay_two =
            relay_cond(i_relay_two_select, cond) || kp2; // see RULE_19
        next_st.kp_err = kp_err;
        next_st.fdt = fdt.mode;
        if (!i_rst_b)
        begin
            next_st = '0; // see RULE_21
        end
    end

    // one register stage keeps relay drive glitch free
    always_ff @(posedge i_clk)
    begin
        st <= next_st; // see RULE_21
    end

    assign o_relay_one = st.relay_one;
    assign o_relay_two = st.relay_two;
    assign o_keypad_error = st.kp_err;
    assign o_freq_detect = st.fdt;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_reset;
        @(posedge i_clk) disable iff (1'b0)
        !i_rst_b |=> !o_relay_one && !o_relay_two && !o_keypad_error;
    endproperty
    a_reset: assert property (p_reset) // see RULE_21
        else $error("relays not cleared by reset");

    property p_sel_mode1;
        (i_relay_one_select == SEL_MODE1) && !kp1
            |=> o_relay_one == $past(fdt.mode[DET_ONE]);
    endproperty
    a_sel_mode1: assert property (p_sel_mode1) // see RULE_01
        else $error("relay one does not follow mode one");

    property p_mode_one;
        (i_cmd_freq == i_run_freq)
            ##1 ((i_relay_one_select == SEL_MODE1) && !kp1)
            |=> o_relay_one;
    endproperty
    a_mode_one: assert property (p_mode_one) // see RULE_02
        else $error("mode one off with equal frequencies");

    property p_mode_two;
        (i_cmd_freq != i_detect_freq_level)
            ##1 ((i_relay_two_select == SEL_MODE2) && !kp2)
            |=> !o_relay_two;
    endproperty
    a_mode_two: assert property (p_mode_two) // see RULE_03
        else $error("mode two on away from level");

    property p_mode_three;
        (i_detect_freq_level == i_run_freq)
            ##1 ((i_relay_one_select == SEL_MODE3) && !kp1)
            |=> o_relay_one;
    endproperty
    a_mode_three: assert property (p_mode_three) // see RULE_04
        else $error("mode three off at level");

    property p_mode_four_acc;
        (!i_decel && (i_run_freq < i_detect_freq_level))
            ##1 ((i_relay_one_select == SEL_MODE4) && !kp1)
            |=> !o_relay_one;
    endproperty
    a_mode_four_acc: assert property (p_mode_four_acc) // see RULE_05
        else $error("mode four on below level");

    property p_mode_four_dec;
        // strictly above level: with a band below 2 the edge is the level
        (i_decel && (i_run_freq > i_detect_freq_level))
            ##1 ((i_relay_two_select == SEL_MODE4) && !kp2)
            |=> o_relay_two;
    endproperty
    a_mode_four_dec: assert property (p_mode_four_dec) // see RULE_05
        else $error("mode four off while slowing above level");

    property p_mode_five;
        // detector stage reads all zero for one cycle after reset
        (i_relay_one_select == SEL_MODE5) && !kp1 && $past(i_rst_b)
            |=> o_relay_one == !$past(fdt.mode[DET_FOUR]);
    endproperty
    a_mode_five: assert property (p_mode_five) // see RULE_06
        else $error("mode five not inverse of mode four");

    property p_ov;
        (i_relay_one_select == SEL_OV) && i_ov_trip |=> o_relay_one;
    endproperty
    a_ov: assert property (p_ov) // see RULE_08
        else $error("overvoltage not on relay");

    property p_uv;
        (i_relay_two_select == SEL_UV) && i_uv_trip |=> o_relay_two;
    endproperty
    a_uv: assert property (p_uv) // see RULE_09
        else $error("undervoltage not on relay");

    property p_oh;
        (i_relay_one_select == SEL_OH) && !kp1
            |=> o_relay_one == $past(i_heatsink_overheat_event);
    endproperty
    a_oh: assert property (p_oh) // see RULE_10
        else $error("overheat not followed");

    property p_loss;
        (i_relay_one_select == SEL_LOSS) && !kp1
            |=> o_relay_one == $past(i_analog_ref_lost || i_comm_cmd_lost);
    endproperty
    a_loss: assert property (p_loss) // see RULE_11
        else $error("command loss not followed");

    property p_run;
        (i_relay_one_select == SEL_RUN) && !kp1
            && !(i_run_cmd && i_output_active) |=> !o_relay_one;
    endproperty
    a_run: assert property (p_run) // see RULE_12
        else $error("run relay on without output");

    property p_stop;
        (i_relay_two_select == SEL_STOP) && i_drive_stopped && !i_run_cmd
            |=> o_relay_two;
    endproperty
    a_stop: assert property (p_stop) // see RULE_13
        else $error("stop relay off while stopped");

    property p_const;
        (i_relay_one_select == SEL_CONST) && !kp1 && (i_accel || i_decel)
            |=> !o_relay_one;
    endproperty
    a_const: assert property (p_const) // see RULE_14
        else $error("constant run relay on while ramping");

    property p_wait;
        (i_relay_two_select == SEL_WAIT) && !kp2
            && (any_trip || i_run_cmd) |=> !o_relay_two;
    endproperty
    a_wait: assert property (p_wait) // see RULE_15
        else $error("wait relay on outside normal wait");

    property p_fault_uv;
        (i_relay_two_select == SEL_FAULT) && !kp2 && i_uv_trip && !nonuv
            && (i_fault_relay_mask == FMASK_DFLT) |=> !o_relay_two;
    endproperty
    a_fault_uv: assert property (p_fault_uv) // see RULE_16
        else $error("default mask answered undervoltage");

    property p_fault_bits;
        (i_relay_one_select == SEL_FAULT)
            && ((i_fault_relay_mask[FMASK_TRIP] && nonuv)
            || (i_fault_relay_mask[FMASK_RESTART] && i_restart_pending))
            |=> o_relay_one;
    endproperty
    a_fault_bits: assert property (p_fault_bits) // see RULE_17
        else $error("fault mask bit not answered");

    property p_fan;
        (i_relay_two_select == SEL_FAN) && !kp2
            && (i_fan_trip_behaviour != FAN_KEEP_RUN) |=> !o_relay_two;
    endproperty
    a_fan: assert property (p_fan) // see RULE_18
        else $error("fan alarm given with trip behaviour");

    property p_kp_route;
        kp_err ##1 (kp_err && i_keypad_error_output_mask[KMASK_TWO])
            |=> o_relay_two && o_keypad_error;
    endproperty
    a_kp_route: assert property (p_kp_route) // see RULE_19
        else $error("keypad error not routed to relay two");

    property p_kp_off;
        !i_keypad_link_error |=> ##1 !o_keypad_error;
    endproperty
    a_kp_off: assert property (p_kp_off) // see RULE_20
        else $error("keypad error shown without link error");

    property p_either;
        kp1 |=> o_relay_one;
    endproperty
    a_either: assert property (p_either) // see RULE_22
        else $error("keypad error lost against selected condition");

    c_mode4: cover property ((i_relay_one_select == SEL_MODE4)
        ##1 $rose(o_relay_one));
    c_fault: cover property ((i_relay_two_select == SEL_FAULT)
        && nonuv ##1 o_relay_two);
    c_kp: cover property ($rose(o_keypad_error));
endmodule : rocs_relay_sel

// ==== rocs_relay_contacts.sv ====
`timescale 1ns/1ps
// far side: settings panel and relay contacts read by the sequence
module rocs_relay_contacts
import rocs_pkg::*;
#(
    parameter logic [15:0] LEVEL = DET_LEVEL_DFLT,
    parameter logic [15:0] BW = DET_BW_DFLT,
    parameter logic [15:0] MAX_FREQ = FREQ_SET_MAX
) (
    input wire logic i_relay_one,
    input wire logic i_relay_two,
    output logic [FREQ_W-1:0] o_level,
    output logic [FREQ_W-1:0] o_bw,
    output logic o_contact_one,
    output logic o_contact_two
);
    // panel clamps values above the max frequency limit to that limit
    assign o_level = (LEVEL > MAX_FREQ) ? MAX_FREQ : LEVEL;
    assign o_bw = (BW > MAX_FREQ) ? MAX_FREQ : BW;
    // normally open contacts, closed while energised
    assign o_contact_one = i_relay_one;
    assign o_contact_two = i_relay_two;
endmodule : rocs_relay_contacts

// ==== rocs_relay_sel_tb_top.sv ====
`timescale 1ns/1ps
module rocs_relay_sel_tb_top;
    import rocs_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [15:0] cmd = '0, run = '0, lvl, bw;
    logic acc = 0, dec = 0, ov = 0, uv = 0, oth = 0, oh = 0;
    logic alost = 0, clost = 0, runc = 0, outa = 0, stp = 0, rdy = 0;
    logic rst_p = 0, fan = 0, fanb = 0, kerr = 0;
    logic [4:0] sel1 = 5'h05, sel2 = 5'h05;
    logic [2:0] fmask = FMASK_DFLT;
    logic [1:0] kmask = 2'h0;
    logic r1, r2, c1, c2, kout;
    logic [4:0] fd;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    int codes[12] = '{8, 9, 10, 11, 12, 13, 14, 16, 17, 18, 5, 31};
    int fv[8][3] = '{'{3000, 3500, 0}, '{3000, 3501, 0}, '{2000, 2999, 0},
        '{3000, 2500, 1}, '{3000, 2501, 1}, '{3500, 3000, 0},
        '{3000, 3100, 1}, '{0, 0, 0}};
    int fmv[6] = '{1, 2, 2, 4, 3, 0};
    logic [3:0] fsrc[6] = '{4'h1, 4'h1, 4'h4, 4'h8, 4'h8, 4'h2};
    logic fexp[6] = '{1, 0, 1, 1, 0, 0};

    rocs_relay_sel #(.PERSIST_CYC(4)) u_rocs_relay_sel (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_freq(cmd),
        .i_run_freq(run), .i_detect_freq_level(lvl),
        .i_detect_freq_bandwidth(bw), .i_accel(acc), .i_decel(dec),
        .i_relay_one_select(sel1), .i_relay_two_select(sel2),
        .i_fault_relay_mask(fmask), .i_keypad_error_output_mask(kmask),
        .i_fan_trip_behaviour(fanb), .i_ov_trip(ov), .i_uv_trip(uv),
        .i_other_trip(oth), .i_heatsink_overheat_event(oh),
        .i_analog_ref_lost(alost), .i_comm_cmd_lost(clost),
        .i_run_cmd(runc), .i_output_active(outa), .i_drive_stopped(stp),
        .i_drive_ready(rdy), .i_restart_pending(rst_p),
        .i_fan_fault(fan), .i_keypad_link_error(kerr),
        .o_relay_one(r1), .o_relay_two(r2), .o_keypad_error(kout),
        .o_freq_detect(fd));
    rocs_relay_contacts u_rocs_relay_contacts (
        .i_relay_one(r1), .i_relay_two(r2), .o_level(lvl), .o_bw(bw),
        .o_contact_one(c1), .o_contact_two(c2));

    initial
    begin
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    always @(posedge i_clk)
    begin
        cyc++;
        // whole run needs well under a thousand cycles
        if (cyc == 5000)
        begin
            fail_count++;
            stop_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask : step

    task automatic chk(input logic e1, input logic e2);
        cmp_count++;
        if (c1 !== e1 || c2 !== e2)
        begin
            fail_count++;
            $display("Error %0t relays %b%b expected %b%b", $time, c1, c2,
                e1, e2);
        end
    endtask : chk

    task automatic chk_k(input logic e);
        cmp_count++;
        if (kout !== e)
        begin
            fail_count++;
            $display("Error %0t keypad error %b expected %b", $time, kout, e);
        end
    endtask : chk_k

    task automatic set_cause(input int c, input logic v);
        case (c)
            8: ov = v;
            9: uv = v;
            10: oh = v;
            11: alost = v;
            12: {runc, outa} = {v, v};
            13: stp = v;
            14: outa = v;
            16: rdy = v;
            17: oth = v;
            18: fan = v;
            default: clost = v;
        endcase
    endtask : set_cause

    function automatic logic [4:0] exp_fd(int c, int r, int l, int b, int d);
        logic m1, m4;
        m1 = ((c > r) ? c - r : r - c) <= b / 2;
        m4 = d ? (r > l - b / 2) : (r >= l);
        return {!m4, m4, ((l > r) ? l - r : r - l) <= b / 2, c == l && m1, m1};
    endfunction : exp_fd

    initial
    begin
        logic [4:0] e;
        step(20);
        chk(0, 0);
        chk_k(0);
        i_rst_b = 1'b1;
        step(2);
        for (int i = 0; i < 12; i++)
        begin
            sel1 = codes[i][4:0];
            sel2 = codes[i][4:0];
            set_cause(codes[i], 1);
            step(2);
            chk(i < 10, i < 10);
            set_cause(codes[i], 0);
            step(2);
            chk(0, 0);
        end
        $display("test event codes done");
        {sel1, sel2, runc, clost} = {5'h0b, 5'h0d, 1'b1, 1'b1};
        stp = 1;
        step(2);
        chk(1, 0);
        {sel1, sel2, clost, outa} = {5'h0c, 5'h10, 1'b0, 1'b0};
        rdy = 1;
        step(2);
        chk(0, 0);
        {sel1, sel2, runc, stp, rdy} = {5'h0e, 5'h12, 3'b000};
        {outa, acc, fan, fanb} = 4'b1111;
        step(2);
        chk(0, 0);
        {outa, acc, fan, fanb} = 4'b0000;
        $display("test negative conditions done");
        {sel1, sel2} = {5'h11, 5'h11};
        for (int i = 0; i < 6; i++)
        begin
            fmask = fmv[i][2:0];
            {rst_p, ov, oth, uv} = fsrc[i];
            step(2);
            chk(fexp[i], fexp[i]);
        end
        {rst_p, ov, oth, uv} = 4'h0;
        fmask = FMASK_DFLT;
        $display("test fault mask done");
        for (int i = 0; i < 8; i++)
        begin
            {cmd, run, dec, acc} = {fv[i][0][15:0], fv[i][1][15:0],
                fv[i][2][0], !fv[i][2][0]};
            e = exp_fd(fv[i][0], fv[i][1], lvl, bw, fv[i][2]);
            for (int k = 0; k < 5; k++)
            begin
                {sel1, sel2} = {k[4:0], 5'h04 - k[4:0]};
                step(2);
                chk(e[k], e[4 - k]);
                cmp_count++;
                if (fd !== e)
                begin
                    fail_count++;
                    $display("Error %0t detect %b expected %b", $time, fd, e);
                end
            end
        end
        $display("test frequency detection done");
        {sel1, sel2, kmask, kerr} = {5'h05, 5'h07, 2'h3, 1'b1};
        step(2);
        kerr = 0;
        step(8);
        chk(0, 0);
        kerr = 1;
        step(2);
        chk(0, 0);
        chk_k(0);
        step(8);
        chk(1, 1);
        chk_k(1);
        kmask = 2'h1;
        step(2);
        chk(1, 0);
        {kmask, sel2, ov} = {2'h2, 5'h08, 1'b1};
        step(2);
        chk(0, 1);
        {kmask, kerr} = {2'h0, 1'b0};
        step(6);
        chk(0, 1);
        chk_k(0);
        i_rst_b = 1'b0;
        step(2);
        chk(0, 0);
        i_rst_b = 1'b1;
        step(2);
        chk(0, 1);
        ov = 0;
        $display("test keypad error done");
        stop_test();
    end
endmodule : rocs_relay_sel_tb_top
